//--- src/aux_pin_defs.vh
// register map, field layout, reset values and mode codes for the aux pin mux
`ifndef AUX_PIN_DEFS_VH
`define AUX_PIN_DEFS_VH

// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define AUX_OFS_CTRL    8'h00
`define AUX_OFS_NVMPROG 8'h04
`define AUX_OFS_GPIO    8'h08
`define AUX_OFS_STATUS  8'h0C
`define AUX_OFS_ACTIVE  8'h10

// ---------------------------------------------
// configuration word fields
// ---------------------------------------------
`define AUX_CFG_FUNC_LO 0
`define AUX_CFG_FUNC_HI 3
`define AUX_CFG_CHGOVR  4
`define AUX_CFG_GPIOEN  5
`define AUX_NVM_IDX_LO  8
`define AUX_NVM_IDX_HI  9
`define AUX_CTRL_RELOAD 0
`define AUX_GPIO_VAL    0
`define AUX_GPIO_DIR    1

// ---------------------------------------------
// reset values and sizes
// ---------------------------------------------
`define AUX_CFG_DEFAULT 8'h00
`define AUX_PIN_INDEX   2'h3
`define AUX_NVM_DEPTH   4

// ---------------------------------------------
// function selection codes
// ---------------------------------------------
`define AUX_F_TRISTATE  4'h0
`define AUX_F_DRIVE1    4'h1
`define AUX_F_DRIVE0    4'h2
`define AUX_F_POWER_ENABLE_N     4'h3
`define AUX_F_SLEEP     4'h4
`define AUX_F_CLKFAST   4'h5
`define AUX_F_CLKMID    4'h6
`define AUX_F_CLKSLOW   4'h7
`define AUX_F_GPIO      4'h8
`define AUX_F_CHGDET    4'h9
`define AUX_F_CHGDETN   4'hA
`define AUX_F_WRSTB     4'hB
`define AUX_F_RDSTB     4'hC
`define AUX_F_VBUS      4'hD
`define AUX_F_TSTAMP    4'hE
`define AUX_F_KEEPAWAKE 4'hF

// ---------------------------------------------
// clock synthesis: 16-bit phase accumulator at 20 MHz
// inc = 2 * f * 2^16 / 20e6, saturated at 2^16 (toggle every cycle)
// ---------------------------------------------
`define AUX_NCO_W       16
`define AUX_NCO_FAST    17'h1_0000
`define AUX_NCO_MID     17'h1_0000
`define AUX_NCO_SLOW    17'h0_999A

`endif

//--- src/aux_cfg_nvm.v
// small configuration memory holding one function word per aux pin
`timescale 1ns/1ps
module aux_cfg_nvm #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clock,
   input  wire             clockEnable,
   input  wire             wrEn,
   input  wire [AW-1:0]    wrAddr,
   input  wire [WIDTH-1:0] wrData,
   input  wire [AW-1:0]    rdAddr,
   output reg  [WIDTH-1:0] rdData_q
);
`include "aux_pin_defs.vh"

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   integer         i;

   // contents stand for factory defaults; reset leaves them alone
   initial
   begin
      for (i = 0; i < DEPTH; i = i + 1)
         mem[i] = `AUX_CFG_DEFAULT;
   end

   // one write port, registered read port
   always @(posedge clock)
   begin
      if (clockEnable)
      begin
         if (wrEn)
            mem[wrAddr] <= wrData;
         rdData_q <= mem[rdAddr];
      end
   end
endmodule

//--- src/aux_clk_nco.v
// phase accumulator clock generator, held low while not running
`timescale 1ns/1ps
module aux_clk_nco #(
   parameter ACC_W = 16
) (
   input  wire           clock,
   input  wire           srst,
   input  wire           clockEnable,
   input  wire           run,
   input  wire [ACC_W:0] inc,
   output reg            clkOut_q
);
   reg  [ACC_W-1:0] acc_q;
   wire [ACC_W:0]   sum;

   // carry out marks a half period; inc of 2^ACC_W toggles every cycle
   assign sum = {1'b0, acc_q} + inc;

   // stopped output restarts from a clean low phase
   always @(posedge clock)
   begin
      if (srst)
      begin
         acc_q    <= {ACC_W{1'b0}};
         clkOut_q <= 1'b0;
      end
      else if (clockEnable)
      begin
         if (!run)
         begin
            acc_q    <= {ACC_W{1'b0}};
            clkOut_q <= 1'b0;
         end
         else
         begin
            acc_q <= sum[ACC_W-1:0];
            if (sum[ACC_W])
               clkOut_q <= ~clkOut_q;
         end
      end
   end
endmodule

//--- src/aux_pin_mux.v
// configurable aux pin function selector with ahb-lite register slave
//
// Overview of operation
// - static options tri-state the pad or drive constant one or zero
// - function selection is loaded from config memory, not runtime pins
// - power enable is low once usb configured, released high in suspend
// - power enable is open drain, pulls low only, no internal pull-up
// - sleep indicator is low during usb suspend, high otherwise
// - charger override option forces sleep indicator high on a charger port
// - clock modes output a free-running fast, mid or slow clock
// - any clock output stops while the usb link is suspended
// - gpio mode is software io, enabled per pin in config memory
// - charger detect mode drives high on a dedicated charger, else low
// - inverted charger detect pulls low open drain while charger seen
// - write strobe mode outputs the active-low bit-bang write strobe
// - read strobe mode outputs the active-low bit-bang read strobe
// - bus voltage sense mode samples the pin as bus power presence
// - time stamp mode toggles the pin on each start-of-frame
// - keep awake mode: pin held low blocks entry into usb suspend
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
module aux_pin_mux #(
   parameter NVM_DEPTH = 4,
   parameter NVM_AW    = 2
) (
   input  wire        clock,
   input  wire        srst,
   input  wire        clockEnable,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata_q,
   output reg         hreadyout_q,
   output reg         hresp_q,
   // usb core status and bit-bang strobes
   input  wire        usbConfigured,
   input  wire        usbSuspend,
   input  wire        chargerDetected,
   input  wire        sofPulse,
   input  wire        bitbangWriteStrobeN,
   input  wire        bitbangReadStrobeN,
   // aux_pin_3 pad
   input  wire        auxPin3In,
   output reg         auxPin3Out_q,
   output reg         auxPin3Oe_q,
   // sensed functions back to the usb core
   output reg         vbusPresent_q,
   output reg         suspendBlock_q
);
`include "aux_pin_defs.vh"

   // ---------------------------------------------
   // local state codes
   // ---------------------------------------------
   localparam [1:0] ST_LOAD_REQ  = 2'd0;
   localparam [1:0] ST_LOAD_WAIT = 2'd1;
   localparam [1:0] ST_RUN       = 2'd2;

   // ---------------------------------------------
   // declarations
   // ---------------------------------------------
   reg  [1:0]  state_q;
   reg  [1:0]  state_d;
   reg  [7:0]  cfg_q;
   reg  [7:0]  cfg_d;
   reg  [1:0]  gpio_q;
   reg         stamp_q;
   reg         busAct_q;
   reg         busWr_q;
   reg  [7:0]  busAddr_q;
   reg         reloadReq;
   reg         nvmWrEn;
   reg  [31:0] rdMux;
   reg         padOut;
   reg         padOe;
   reg  [16:0] ncoInc;
   reg         clkRun;
   wire        addrPhase;
   wire [7:0]  nvmRdData;
   wire        clkOut;
   wire [3:0]  func;

   assign func = cfg_q[`AUX_CFG_FUNC_HI:`AUX_CFG_FUNC_LO];

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   // true for modes that use the pad as an input
   function isInputMode;
      input [3:0] f;
      begin
         isInputMode = (f == `AUX_F_VBUS) || (f == `AUX_F_KEEPAWAKE);
      end
   endfunction

   // true for the three clock output modes
   function isClockMode;
      input [3:0] f;
      begin
         isClockMode = (f == `AUX_F_CLKFAST) || (f == `AUX_F_CLKMID) ||
                       (f == `AUX_F_CLKSLOW);
      end
   endfunction

   // ---------------------------------------------
   // configuration memory and clock generator
   // ---------------------------------------------
   aux_cfg_nvm #(
      .WIDTH (8),
      .DEPTH (NVM_DEPTH),
      .AW    (NVM_AW)
   ) uNvm (
      .clock       (clock),
      .clockEnable (clockEnable),
      .wrEn        (nvmWrEn),
      .wrAddr      (hwdata[`AUX_NVM_IDX_LO+NVM_AW-1:`AUX_NVM_IDX_LO]),
      .wrData      (hwdata[7:0]),
      .rdAddr      (`AUX_PIN_INDEX),
      .rdData_q    (nvmRdData)
   );

   aux_clk_nco #(
      .ACC_W (`AUX_NCO_W)
   ) uNco (
      .clock       (clock),
      .srst        (srst),
      .clockEnable (clockEnable),
      .run         (clkRun),
      .inc         (ncoInc),
      .clkOut_q    (clkOut)
   );

   // clock rate pick; generator halts in suspend and outside clock modes
   always @*
   begin
      clkRun = isClockMode(func) && (state_q == ST_RUN) && !usbSuspend;
      case (func)
         `AUX_F_CLKFAST: ncoInc = `AUX_NCO_FAST;
         `AUX_F_CLKMID:  ncoInc = `AUX_NCO_MID;
         default:        ncoInc = `AUX_NCO_SLOW;
      endcase
   end

   // ---------------------------------------------
   // ahb-lite slave
   // ---------------------------------------------
   // address phase accepted only on an active transfer with bus ready
   assign addrPhase = hsel && htrans[1] && hready;

   // data-phase write decode; unmapped writes are dropped
   always @*
   begin
      reloadReq = 1'b0;
      nvmWrEn   = 1'b0;
      if (busAct_q && busWr_q)
      begin
         reloadReq = (busAddr_q == `AUX_OFS_CTRL) && hwdata[`AUX_CTRL_RELOAD];
         nvmWrEn   = (busAddr_q == `AUX_OFS_NVMPROG);
      end
   end

   // read data prepared in the address phase, unmapped reads give zero
   always @*
   begin
      rdMux = 32'h0000_0000;
      case (haddr)
         `AUX_OFS_CTRL:    rdMux = {31'h0000_0000, state_q != ST_RUN};
         `AUX_OFS_GPIO:    rdMux = {30'h0000_0000, gpio_q};
         `AUX_OFS_ACTIVE:  rdMux = {24'h00_0000, cfg_q};
         `AUX_OFS_STATUS:  rdMux = {24'h00_0000, stamp_q, suspendBlock_q,
                                    vbusPresent_q, chargerDetected, usbSuspend,
                                    usbConfigured, auxPin3Oe_q, auxPin3In};
         default:          rdMux = 32'h0000_0000;
      endcase
   end

   // bus phase tracking and registered answer; always zero wait, okay
   always @(posedge clock)
   begin
      if (srst)
      begin
         busAct_q    <= 1'b0;
         busWr_q     <= 1'b0;
         busAddr_q   <= 8'h00;
         hrdata_q    <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end
      else if (clockEnable)
      begin
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
         if (hready)
         begin
            busAct_q  <= addrPhase;
            busWr_q   <= addrPhase && hwrite;
            busAddr_q <= haddr;
            if (addrPhase && !hwrite)
               hrdata_q <= rdMux;
         end
      end
   end

   // gpio value and direction; only reach the pad in gpio mode
   always @(posedge clock)
   begin
      if (srst)
         gpio_q <= 2'b00;
      else if (clockEnable && busAct_q && busWr_q &&
               busAddr_q == `AUX_OFS_GPIO)
         gpio_q <= hwdata[1:0];
   end

   // ---------------------------------------------
   // selection loader
   // ---------------------------------------------
   // reset and the reload command fetch the stored selection afresh
   always @*
   begin
      state_d = state_q;
      cfg_d   = cfg_q;
      case (state_q)
         ST_LOAD_REQ:  state_d = ST_LOAD_WAIT;
         ST_LOAD_WAIT:
         begin
            cfg_d   = nvmRdData;
            state_d = ST_RUN;
         end
         ST_RUN:
         begin
            if (reloadReq)
               state_d = ST_LOAD_REQ;
         end
         default:      state_d = ST_LOAD_REQ;
      endcase
   end

   // loader registers; memory read latency is one cycle
   always @(posedge clock)
   begin
      if (srst)
      begin
         state_q <= ST_LOAD_REQ;
         cfg_q   <= `AUX_CFG_DEFAULT;
      end
      else if (clockEnable)
      begin
         state_q <= state_d;
         cfg_q   <= cfg_d;
      end
   end

   // ---------------------------------------------
   // time stamp toggle
   // ---------------------------------------------
   // flips once per start-of-frame pulse, counted only in that mode
   always @(posedge clock)
   begin
      if (srst)
         stamp_q <= 1'b0;
      else if (clockEnable && sofPulse && func == `AUX_F_TSTAMP)
         stamp_q <= ~stamp_q;
   end

   // ---------------------------------------------
   // pad function mux
   // ---------------------------------------------
   // exactly one source reaches the pad; open drain modes drive only low
   always @*
   begin
      padOut = 1'b0;
      padOe  = 1'b0;
      if (state_q == ST_RUN)
      begin
         case (func)
            `AUX_F_TRISTATE: padOe = 1'b0;
            `AUX_F_DRIVE1:
            begin
               padOut = 1'b1;
               padOe  = 1'b1;
            end
            `AUX_F_DRIVE0:   padOe = 1'b1;
            `AUX_F_POWER_ENABLE_N:
            begin
               // released before configuration and in suspend
               padOe = usbConfigured && !usbSuspend;
            end
            `AUX_F_SLEEP:
            begin
               padOe  = 1'b1;
               padOut = !usbSuspend;
               if (cfg_q[`AUX_CFG_CHGOVR] && chargerDetected)
                  padOut = 1'b1;
            end
            `AUX_F_CLKFAST,
            `AUX_F_CLKMID,
            `AUX_F_CLKSLOW:
            begin
               padOe  = 1'b1;
               padOut = clkOut;
            end
            `AUX_F_GPIO:
            begin
               if (cfg_q[`AUX_CFG_GPIOEN])
               begin
                  padOe  = gpio_q[`AUX_GPIO_DIR];
                  padOut = gpio_q[`AUX_GPIO_VAL];
               end
            end
            `AUX_F_CHGDET:
            begin
               padOe  = 1'b1;
               padOut = chargerDetected;
            end
            `AUX_F_CHGDETN:  padOe = chargerDetected;
            `AUX_F_WRSTB:
            begin
               padOe  = 1'b1;
               padOut = bitbangWriteStrobeN;
            end
            `AUX_F_RDSTB:
            begin
               padOe  = 1'b1;
               padOut = bitbangReadStrobeN;
            end
            `AUX_F_TSTAMP:
            begin
               padOe  = 1'b1;
               padOut = stamp_q;
            end
            default:         padOe = 1'b0; // input modes leave the pad alone
         endcase
      end
   end

   // ---------------------------------------------
   // pad and sense registers
   // ---------------------------------------------
   // one stage of delay keeps every output on a flop; input modes
   // report their sense only when selected, otherwise a neutral level
   always @(posedge clock)
   begin
      if (srst)
      begin
         auxPin3Out_q   <= 1'b0;
         auxPin3Oe_q    <= 1'b0;
         vbusPresent_q  <= 1'b0;
         suspendBlock_q <= 1'b0;
      end
      else if (clockEnable)
      begin
         auxPin3Out_q <= padOut;
         auxPin3Oe_q  <= padOe && !isInputMode(func);
         vbusPresent_q <= (state_q == ST_RUN) && func == `AUX_F_VBUS &&
                          auxPin3In;
         suspendBlock_q <= (state_q == ST_RUN) && func == `AUX_F_KEEPAWAKE &&
                           !auxPin3In;
      end
   end
endmodule

//--- tb/aux_pin_mux_sva.sv
// concurrent checks on the aux pin mux ports
`timescale 1ns/1ps
`include "aux_pin_defs.vh"
module aux_pin_mux_sva (
   input wire logic        clock,
   input wire logic        srst,
   input wire logic        clockEnable,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        usbConfigured,
   input wire logic        usbSuspend,
   input wire logic        chargerDetected,
   input wire logic        sofPulse,
   input wire logic        bitbangWriteStrobeN,
   input wire logic        bitbangReadStrobeN,
   input wire logic        auxPin3In,
   input wire logic        auxPin3Out_q,
   input wire logic        auxPin3Oe_q,
   input wire logic        vbusPresent_q,
   input wire logic        suspendBlock_q
);
   // ------------------------------------------------
   // bus snoop
   // ------------------------------------------------
   // mirrors the live function word; prog_q has no reset since the memory keeps it
   logic [7:0] prog_q = 8'h00;
   logic [7:0] mode_q;
   logic [7:0] addr_q;
   logic       wr_q;
   logic [2:0] wait_q;
   wire  [3:0] func    = mode_q[3:0];
   wire        settled = (wait_q == 3'h0);
   always @(posedge clock)
   begin
      wr_q   <= hsel & htrans[1] & hready & clockEnable & hwrite & ~srst;
      addr_q <= haddr;
      if (wr_q && addr_q == `AUX_OFS_NVMPROG && hwdata[9:8] == `AUX_PIN_INDEX)
         prog_q <= hwdata[7:0];
      // loader takes three edges; two spare edges before the pad is judged
      if (srst || (wr_q && addr_q == `AUX_OFS_CTRL && hwdata[`AUX_CTRL_RELOAD]))
      begin
         mode_q <= prog_q;
         wait_q <= 3'h5;
      end
      else if (wait_q != 3'h0)
         wait_q <= wait_q - 3'h1;
   end
   // ------------------------------------------------
   // assertions
   // ------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // a frame marker seen in time stamp mode, then one edge
   sequence sSofSeen;
      settled && func == `AUX_F_TSTAMP && sofPulse ##1 settled;
   endsequence
   chk_reset_quiet: assert property ($fell(srst) |->
      !auxPin3Oe_q && !vbusPresent_q && !suspendBlock_q) else $error("pad not idle");
   chk_static_pad: assert property (settled && func <= `AUX_F_DRIVE0 |->
      auxPin3Oe_q == (func != `AUX_F_TRISTATE) &&
      (!auxPin3Oe_q || auxPin3Out_q == (func == `AUX_F_DRIVE1))) else $error("static pad");
   chk_power_enable_n_drain: assert property (settled && func == `AUX_F_POWER_ENABLE_N |->
      !auxPin3Out_q && auxPin3Oe_q == $past(usbConfigured && !usbSuspend))
      else $error("power enable pad");
   chk_sleep_level: assert property (settled && func == `AUX_F_SLEEP |->
      auxPin3Oe_q && auxPin3Out_q == $past(!usbSuspend || (mode_q[4] && chargerDetected)))
      else $error("sleep pad");
   chk_clk_stop: assert property (settled && func >= `AUX_F_CLKFAST &&
      func <= `AUX_F_CLKSLOW && $past(usbSuspend, 2) |-> !auxPin3Out_q) else $error("clock on");
   chk_clk_fast: assert property (settled && func == `AUX_F_CLKFAST &&
      !$past(usbSuspend) && !$past(usbSuspend, 2) |-> auxPin3Out_q != $past(auxPin3Out_q))
      else $error("fast clock stuck");
   chk_chg_level: assert property (settled && func == `AUX_F_CHGDET |->
      auxPin3Oe_q && auxPin3Out_q == $past(chargerDetected)) else $error("charger pad");
   chk_chg_drain: assert property (settled && func == `AUX_F_CHGDETN |->
      !auxPin3Out_q && auxPin3Oe_q == $past(chargerDetected)) else $error("charger drain");
   chk_strobe_follow: assert property (settled &&
      (func == `AUX_F_WRSTB || func == `AUX_F_RDSTB) |-> auxPin3Oe_q && auxPin3Out_q ==
      $past(func == `AUX_F_WRSTB ? bitbangWriteStrobeN : bitbangReadStrobeN))
      else $error("strobe pad");
   chk_vbus_sense: assert property (settled && func == `AUX_F_VBUS |->
      !auxPin3Oe_q && vbusPresent_q == $past(auxPin3In)) else $error("bus sense");
   chk_awake_sense: assert property (settled && func == `AUX_F_KEEPAWAKE |->
      !auxPin3Oe_q && suspendBlock_q == $past(!auxPin3In)) else $error("keep awake");
   chk_sense_idle: assert property (settled && func != `AUX_F_VBUS &&
      func != `AUX_F_KEEPAWAKE |-> !vbusPresent_q && !suspendBlock_q) else $error("sense");
   chk_sof_toggle: assert property (sSofSeen |=>
      auxPin3Out_q != $past(auxPin3Out_q)) else $error("time stamp not toggled");
endmodule

//--- tb/aux_pad_partner.sv
// far side of the aux pad: board pull-up plus an external driver
`timescale 1ns/1ps
module aux_pad_partner (
   input  wire logic padOut,
   input  wire logic padOe,
   input  wire logic extEn,
   input  wire logic extLvl,
   output wire logic padLvl
);
   // ------------------------------------------------
   // pad resolution
   // ------------------------------------------------
   // pull-up gives the high level of drain-only modes
   // external logic drives the sense inputs only while enabled
   assign padLvl = padOe ? padOut : (extEn ? extLvl : 1'b1);
endmodule

//--- tb/aux_pin_mux_tb.sv
// self-checking bench for the aux pin function selector
`timescale 1ns/1ps
`include "aux_pin_defs.vh"
module aux_pin_mux_tb;
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        usbConfigured = 1'b0;
   logic        usbSuspend = 1'b0;
   logic        chargerDetected = 1'b0;
   logic        sofPulse = 1'b0;
   logic        wrStbN = 1'b1;
   logic        rdStbN = 1'b1;
   logic        extEn = 1'b0;
   logic        extLvl = 1'b0;
   wire  [31:0] hrdata_q;
   wire         hreadyout_q;
   wire         hresp;
   wire         padOut;
   wire         padOe;
   wire         padLvl;
   wire         vbusPresent_q;
   wire         suspendBlock_q;
   int          errorCnt = 0;
   int          numChecks = 0;
   // ------------------------------------------------
   // design, pad partner and clock
   // ------------------------------------------------
   // enable, select and size tied: the bus is single-slave and whole-word
   aux_pin_mux i_aux_pin_mux (
      .clock(clock), .srst(srst), .clockEnable(1'b1), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout_q), .hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q), .hresp_q(hresp),
      .usbConfigured(usbConfigured), .usbSuspend(usbSuspend),
      .chargerDetected(chargerDetected), .sofPulse(sofPulse),
      .bitbangWriteStrobeN(wrStbN), .bitbangReadStrobeN(rdStbN), .auxPin3In(padLvl),
      .auxPin3Out_q(padOut), .auxPin3Oe_q(padOe), .vbusPresent_q(vbusPresent_q),
      .suspendBlock_q(suspendBlock_q));
   aux_pad_partner i_aux_pad_partner (
      .padOut(padOut), .padOe(padOe), .extEn(extEn), .extLvl(extLvl), .padLvl(padLvl));
   always #25 clock = ~clock;
   // ------------------------------------------------
   // checks and bus tasks
   // ------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      numChecks++;
      if (g !== e)
      begin
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
         errorCnt++;
      end
   endtask
   task automatic chkRange(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
      numChecks++;
      if (!(g >= lo && g <= hi))
      begin
         $display("FAIL t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
         errorCnt++;
      end
   endtask
   // {bus error, vbus sense, keep awake, drive enable, pad level}, two edges on
   task automatic padChk(input logic [3:0] e);
      repeat (2) @(posedge clock);
      chk({27'h0, hresp, vbusPresent_q, suspendBlock_q, padOe, padLvl}, {28'h0, e});
   endtask
   // one single transfer: address phase held until ready, then the data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      @(posedge clock);
      hwrite <= w;
      haddr  <= a;
      htrans <= 2'h2;
      @(posedge clock);
      while (hreadyout_q !== 1'b1) @(posedge clock);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock);
      while (hreadyout_q !== 1'b1) @(posedge clock);
      r = hrdata_q;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0000_0000, r);
      chk(r, e);
   endtask
   // stores the word for this pad and reloads; the loader needs three edges
   task automatic setMode(input logic [7:0] cfg);
      wr(`AUX_OFS_NVMPROG, {22'h0, `AUX_PIN_INDEX, cfg});
      wr(`AUX_OFS_CTRL, 32'h0000_0001);
      repeat (4) @(posedge clock);
   endtask
   task summarize;
      if (errorCnt == 0 && numChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ------------------------------------------------
   // watchdog
   // ------------------------------------------------
   // the whole sequence needs well under a thousand cycles; ten thousand is ample
   initial
   begin
      #(50 * 10000);
      errorCnt++;
      summarize();
   end
   // ------------------------------------------------
   // test sequence
   // ------------------------------------------------
   initial
   begin
      int          m;
      int          i;
      logic [31:0] cnt;
      logic [31:0] inc;
      logic        last;
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      repeat (4) @(posedge clock);
      padChk(4'b0001);
      rdChk(`AUX_OFS_ACTIVE, {24'h0, `AUX_CFG_DEFAULT});
      wr(8'h14, 32'h0000_0001);
      rdChk(8'h14, 32'h0000_0000);
      wr(`AUX_OFS_NVMPROG, {22'h0, `AUX_PIN_INDEX, 8'h01});
      padChk(4'b0001);
      for (m = 0; m < 3; m++)
      begin
         setMode(m[7:0]);
         padChk({2'b00, m != 0, m != 2});
      end
      setMode({4'h0, `AUX_F_POWER_ENABLE_N});
      padChk(4'b0001);
      @(posedge clock) usbConfigured <= 1'b1;
      padChk(4'b0010);
      @(posedge clock) usbSuspend <= 1'b1;
      padChk(4'b0001);
      setMode({4'h0, `AUX_F_SLEEP});
      padChk(4'b0010);
      @(posedge clock) chargerDetected <= 1'b1;
      padChk(4'b0010);
      setMode({4'h1, `AUX_F_SLEEP});
      padChk(4'b0011);
      @(posedge clock) usbSuspend <= 1'b0;
      padChk(4'b0011);
      for (m = 5; m < 8; m++)
      begin
         setMode(m[7:0]);
         inc = (m == 7) ? {15'h0, `AUX_NCO_SLOW} : {15'h0, `AUX_NCO_FAST};
         cnt = 0;
         last = padLvl;
         for (i = 0; i < 64; i++)
         begin
            @(posedge clock);
            if (padLvl !== last) cnt++;
            last = padLvl;
         end
         chkRange(cnt, ((inc * 64) >> 16) - 1, ((inc * 64) >> 16) + 1);
         @(posedge clock) usbSuspend <= 1'b1;
         repeat (2) @(posedge clock);
         cnt = 0;
         for (i = 0; i < 16; i++)
         begin
            @(posedge clock);
            if (padLvl !== 1'b0) cnt++;
         end
         chk(cnt, 32'h0000_0000);
         @(posedge clock) usbSuspend <= 1'b0;
      end
      setMode(8'h28);
      wr(`AUX_OFS_GPIO, 32'h0000_0003);
      padChk(4'b0011);
      rdChk(`AUX_OFS_GPIO, 32'h0000_0003);
      wr(`AUX_OFS_GPIO, 32'h0000_0002);
      padChk(4'b0010);
      wr(`AUX_OFS_GPIO, 32'h0000_0000);
      padChk(4'b0001);
      setMode({4'h0, `AUX_F_CHGDET});
      padChk(4'b0011);
      @(posedge clock) chargerDetected <= 1'b0;
      padChk(4'b0010);
      setMode({4'h0, `AUX_F_CHGDETN});
      padChk(4'b0001);
      @(posedge clock) chargerDetected <= 1'b1;
      padChk(4'b0010);
      for (m = 11; m < 13; m++)
      begin
         setMode(m[7:0]);
         @(posedge clock) wrStbN <= (m == 12);
         rdStbN <= (m == 11);
         padChk(4'b0010);
         @(posedge clock) wrStbN <= 1'b1;
         rdStbN <= 1'b1;
         padChk(4'b0011);
      end
      setMode({4'h0, `AUX_F_TSTAMP});
      last = padLvl;
      for (i = 0; i < 3; i++)
      begin
         @(posedge clock) sofPulse <= 1'b1;
         @(posedge clock) sofPulse <= 1'b0;
      end
      padChk({3'b001, ~last});
      setMode({4'h0, `AUX_F_VBUS});
      @(posedge clock) extEn <= 1'b1;
      padChk(4'b0000);
      @(posedge clock) extLvl <= 1'b1;
      padChk(4'b1001);
      rdChk(`AUX_OFS_STATUS, 32'h0000_00B5);
      setMode({4'h0, `AUX_F_KEEPAWAKE});
      @(posedge clock) extLvl <= 1'b0;
      padChk(4'b0100);
      @(posedge clock) extEn <= 1'b0;
      padChk(4'b0001);
      summarize();
   end
endmodule
bind aux_pin_mux aux_pin_mux_sva i_aux_pin_mux_sva (
   .clock(clock), .srst(srst), .clockEnable(clockEnable), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .usbConfigured(usbConfigured), .usbSuspend(usbSuspend),
   .chargerDetected(chargerDetected), .sofPulse(sofPulse),
   .bitbangWriteStrobeN(bitbangWriteStrobeN), .bitbangReadStrobeN(bitbangReadStrobeN),
   .auxPin3In(auxPin3In), .auxPin3Out_q(auxPin3Out_q), .auxPin3Oe_q(auxPin3Oe_q),
   .vbusPresent_q(vbusPresent_q), .suspendBlock_q(suspendBlock_q));
